// ### lnb_bus_ctl.sv
`timescale 1ns/10ps
module lnb_bus_ctl #(
  parameter int HALF = 10
) (
  input  wire logic i_mclk,
  input  wire logic i_sda,
  output logic      o_scl_oe_n,
  output logic      o_sda_oe_n
);
  initial begin
    o_scl_oe_n = 1'b1;
    o_sda_oe_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic set_scl(input logic v);
    tick(1);
    o_scl_oe_n <= v;
    tick(HALF);
  endtask

  task automatic start();
    tick(1);
    o_sda_oe_n <= 1'b0;
    tick(HALF);
    o_scl_oe_n <= 1'b0;
    tick(HALF);
  endtask

  task automatic stop();
    o_sda_oe_n <= 1'b0;
    tick(HALF);
    o_scl_oe_n <= 1'b1;
    tick(HALF);
    o_sda_oe_n <= 1'b1;
    tick(HALF);
  endtask

  // Data moves HALF cycles after the fall, halfway through the low phase, never beside a clock edge
  task automatic clk_bit(input logic b, output logic s);
    o_sda_oe_n <= b;
    tick(HALF);
    o_scl_oe_n <= 1'b1;
    tick(HALF);
    s = i_sda;
    o_scl_oe_n <= 1'b0;
    tick(HALF);
  endtask

  task automatic send(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, ack_n);
  endtask

  // Line released for every data bit; ack_n is the controller's answer
  task automatic recv(input logic ack_n, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(ack_n, s);
  endtask
endmodule // lnb_bus_ctl

// ### lnb_ctrl_top.sv
`timescale 1ns/10ps
module lnb_ctrl_top (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_scl,
  output logic            o_scl,
  output logic            o_scl_oe_n,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe_n,
  input  wire logic       i_en_pin,
  input  wire logic       i_voltage_select_pin,
  input  wire logic [1:0] i_addr_strap,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_we,
  input  wire logic       i_re,
  output logic      [7:0] o_rdata,
  output logic            o_out_en,
  output logic      [3:0] o_out_code
);

  typedef struct packed {
    lnb_pkg::lnb_state_t st;
    logic [3:0]          cnt;
    logic [7:0]          sh;
    logic                rw;
    logic [7:0]          ptr;
    logic [7:0]          ctrl1;
    logic [7:0]          ctrl2;
    logic                sda_oe_n;
    logic [7:0]          rdata;
    lnb_pkg::lnb_level_t out;
    logic [6:0]          addr;
    logic [1:0]          settle;
    logic                strap_arm;
    logic                strap_done;
    logic                scl_q;
    logic                sda_q;
  } lnb_top_st_t;

  lnb_top_st_t         top_r;
  lnb_top_st_t         top_nxt;
  lnb_pkg::lnb_pins_t  pins;
  lnb_pkg::lnb_level_t lvl;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_cond;
  logic                stop_cond;
  logic                shifting;
  logic                byte_end;

  // Bus lines idle high, straps and controls arbitrary
  lnb_pin_sync #(
    .W       (6),
    .RST_VAL (6'h03)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_pin   ({i_addr_strap, i_en_pin, i_voltage_select_pin, i_scl, i_sda}),
    .o_level (pins)
  );

  lnb_level_sel u_sel (
    .i_bus_sel  (top_r.ctrl1[lnb_pkg::C1_BUS_SEL]),
    .i_reg_code (top_r.ctrl1[lnb_pkg::C1_CODE_MSB:lnb_pkg::C1_CODE_LSB]),
    .i_reg_en   (top_r.ctrl2[lnb_pkg::C2_OUT_EN]),
    .i_pin_en   (pins.en_pin),
    .i_scl      (pins.scl),
    .i_voltage_select_pin (pins.voltage_select_pin),
    .o_level    (lvl)
  );

  function automatic logic [6:0] strap_addr(input logic [1:0] s);
    logic [6:0] a;
    a = lnb_pkg::ADDR_VCC;
    unique case (lnb_pkg::lnb_strap_t'(s))
      lnb_pkg::STRAP_VCC:   a = lnb_pkg::ADDR_VCC;
      lnb_pkg::STRAP_FLOAT: a = lnb_pkg::ADDR_FLOAT;
      lnb_pkg::STRAP_GND:   a = lnb_pkg::ADDR_GND;
      lnb_pkg::STRAP_DIV:   a = lnb_pkg::ADDR_DIV;
    endcase
    return a;
  endfunction

  // Shared by the plain port and the two-wire read path
  function automatic logic [7:0] rd_mux(input logic [7:0] idx, input lnb_top_st_t s);
    logic [7:0] d;
    d = 8'h00;
    if (idx == lnb_pkg::REG_CTRL1) begin
      d = s.ctrl1;
    end else if (idx == lnb_pkg::REG_CTRL2) begin
      d = s.ctrl2;
    end else if (idx == lnb_pkg::REG_STATUS) begin
      d[lnb_pkg::ST_OUT_EN] = s.out.en;
      d[lnb_pkg::ST_CODE_MSB:lnb_pkg::ST_CODE_LSB] = s.out.code;
      d[lnb_pkg::ST_BUSY] = (s.st != lnb_pkg::ST_IDLE);
    end
    return d;
  endfunction

  assign scl_rise   = pins.scl & ~top_r.scl_q;
  assign scl_fall   = ~pins.scl & top_r.scl_q;
  // Framing comes only from the controller
  assign start_cond = top_r.sda_q & ~pins.sda & pins.scl & top_r.scl_q;
  assign stop_cond  = ~top_r.sda_q & pins.sda & pins.scl & top_r.scl_q;
  assign shifting   = (top_r.st == lnb_pkg::ST_ADDR) || (top_r.st == lnb_pkg::ST_REG) ||
                      (top_r.st == lnb_pkg::ST_WDATA);
  assign byte_end   = scl_fall && (top_r.cnt == lnb_pkg::BYTE_BITS);

  always_comb begin
    top_nxt       = top_r;
    top_nxt.scl_q = pins.scl;
    top_nxt.sda_q = pins.sda;
    top_nxt.out   = lvl;
    top_nxt.rdata = 8'h00;

    // Strap is caught after the filter has settled, never under reset
    // Filter output is valid only one edge after the settle count ends
    if (!top_r.strap_done) begin
      if (top_r.strap_arm) begin
        top_nxt.addr       = strap_addr(pins.strap);
        top_nxt.strap_done = 1'b1;
      end else if (top_r.settle == lnb_pkg::STRAP_SETTLE) begin
        top_nxt.strap_arm = 1'b1;
      end else begin
        top_nxt.settle = top_r.settle + 2'h1;
      end
    end

    if (i_re) begin
      top_nxt.rdata = rd_mux(i_addr, top_r);
    end
    // Plain-port access works whatever the control source
    if (i_we) begin
      if (i_addr == lnb_pkg::REG_CTRL1) begin
        top_nxt.ctrl1 = i_wdata;
      end else if (i_addr == lnb_pkg::REG_CTRL2) begin
        top_nxt.ctrl2 = i_wdata;
      end
    end

    if (shifting && scl_rise) begin
      top_nxt.sh  = {top_r.sh[6:0], pins.sda};
      top_nxt.cnt = top_r.cnt + 4'h1;
    end

    if (!top_r.strap_done) begin
      top_nxt.st       = lnb_pkg::ST_IDLE;
      top_nxt.sda_oe_n = 1'b1;
    end else if (start_cond) begin
      top_nxt.st       = lnb_pkg::ST_ADDR;
      top_nxt.cnt      = 4'h0;
      top_nxt.sda_oe_n = 1'b1;
    end else if (stop_cond) begin
      top_nxt.st       = lnb_pkg::ST_IDLE;
      top_nxt.sda_oe_n = 1'b1;
    end else begin
      unique case (top_r.st)
        lnb_pkg::ST_IDLE, lnb_pkg::ST_SKIP: begin
          top_nxt.sda_oe_n = 1'b1;
        end
        lnb_pkg::ST_ADDR: begin
          if (byte_end) begin
            top_nxt.cnt = 4'h0;
            // General call and 10-bit prefixes never equal a strap address
            if (top_r.sh[7:1] == top_r.addr) begin
              top_nxt.rw       = top_r.sh[0];
              top_nxt.st       = lnb_pkg::ST_ADDR_ACK;
              top_nxt.sda_oe_n = 1'b0;
            end else begin
              top_nxt.st = lnb_pkg::ST_SKIP;
            end
          end
        end
        lnb_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            top_nxt.cnt = 4'h0;
            if (top_r.rw) begin
              top_nxt.st       = lnb_pkg::ST_RDATA;
              top_nxt.sh       = rd_mux(top_r.ptr, top_r);
              top_nxt.sda_oe_n = top_nxt.sh[7];
            end else begin
              top_nxt.st       = lnb_pkg::ST_REG;
              top_nxt.sda_oe_n = 1'b1;
            end
          end
        end
        lnb_pkg::ST_REG: begin
          if (byte_end) begin
            top_nxt.cnt      = 4'h0;
            top_nxt.ptr      = top_r.sh;
            top_nxt.st       = lnb_pkg::ST_REG_ACK;
            top_nxt.sda_oe_n = 1'b0;
          end
        end
        lnb_pkg::ST_REG_ACK, lnb_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            top_nxt.st       = lnb_pkg::ST_WDATA;
            top_nxt.sda_oe_n = 1'b1;
          end
        end
        lnb_pkg::ST_WDATA: begin
          if (byte_end) begin
            // Applied on the falling edge after the last bit; wins over the plain port
            if (top_r.ptr == lnb_pkg::REG_CTRL1) begin
              top_nxt.ctrl1 = top_r.sh;
            end else if (top_r.ptr == lnb_pkg::REG_CTRL2) begin
              top_nxt.ctrl2 = top_r.sh;
            end
            top_nxt.cnt      = 4'h0;
            top_nxt.ptr      = top_r.ptr + 8'h01;
            top_nxt.st       = lnb_pkg::ST_WDATA_ACK;
            top_nxt.sda_oe_n = 1'b0;
          end
        end
        lnb_pkg::ST_RDATA: begin
          if (scl_rise) begin
            top_nxt.cnt = top_r.cnt + 4'h1;
          end
          if (byte_end) begin
            top_nxt.cnt      = 4'h0;
            top_nxt.ptr      = top_r.ptr + 8'h01;
            top_nxt.st       = lnb_pkg::ST_RDATA_ACK;
            top_nxt.sda_oe_n = 1'b1;
          end else if (scl_fall) begin
            top_nxt.sh       = {top_r.sh[6:0], 1'b0};
            top_nxt.sda_oe_n = top_r.sh[6];
          end
        end
        lnb_pkg::ST_RDATA_ACK: begin
          // Controller not-acknowledge ends the read until stop or restart
          if (scl_rise && pins.sda) begin
            top_nxt.st = lnb_pkg::ST_SKIP;
          end else if (scl_fall) begin
            top_nxt.st       = lnb_pkg::ST_RDATA;
            top_nxt.sh       = rd_mux(top_r.ptr, top_r);
            top_nxt.sda_oe_n = top_nxt.sh[7];
          end
        end
        default: begin
          top_nxt.st       = lnb_pkg::ST_IDLE;
          top_nxt.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // Only power-on reset clears the registers; nothing else does
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      top_r            <= '0;
      top_r.st         <= lnb_pkg::ST_IDLE;
      top_r.ctrl1      <= lnb_pkg::CTRL1_RST;
      top_r.ctrl2      <= lnb_pkg::CTRL2_RST;
      top_r.sda_oe_n   <= 1'b1;
      top_r.scl_q      <= 1'b1;
      top_r.sda_q      <= 1'b1;
      top_r.addr       <= lnb_pkg::ADDR_VCC;
    end else begin
      top_r <= top_nxt;
    end
  end

  // Target only: clock line is never pulled, data only low or released
  assign o_scl      = 1'b0;
  assign o_scl_oe_n = 1'b1;
  assign o_sda      = 1'b0;
  assign o_sda_oe_n = top_r.sda_oe_n;
  assign o_rdata    = top_r.rdata;
  assign o_out_en   = top_r.out.en;
  assign o_out_code = top_r.out.code;

endmodule // lnb_ctrl_top

// ### lnb_ctrl_top_assertions.sv
`timescale 1ns/10ps
module lnb_ctrl_chk (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       i_scl,
  input wire logic       o_scl,
  input wire logic       o_scl_oe_n,
  input wire logic       o_sda,
  input wire logic       o_sda_oe_n,
  input wire logic       i_en_pin,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_we,
  input wire logic       i_re,
  input wire logic [7:0] o_rdata,
  input wire logic       o_out_en,
  input wire logic [3:0] o_out_code
);
  // Bus writes to the select bit are not visible here; bench keeps it 0 on the bus
  logic       pin_mode_r;
  logic [3:0] low_cnt_r;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pin_mode_r <= 1'b1;
      low_cnt_r  <= 4'h0;
    end else begin
      if (i_we && i_addr == lnb_pkg::REG_CTRL1) begin
        pin_mode_r <= ~i_wdata[lnb_pkg::C1_BUS_SEL];
      end
      if (i_en_pin || i_we) begin
        low_cnt_r <= 4'h0;
      end else if (low_cnt_r != 4'hf) begin
        low_cnt_r <= low_cnt_r + 4'h1;
      end
    end
  end

  a_scl_released: assert property (o_scl_oe_n && !o_scl)
    else $error("clock line pulled");
  a_sda_low_only: assert property (!o_sda)
    else $error("data line driven high");
  a_ack_scl_low: assert property ($fell(o_sda_oe_n) |-> !i_scl)
    else $error("data pulled while clock high");
  a_rdata_idle: assert property (!i_re |=> o_rdata == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (i_re && i_addr == 8'h02 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_status_mirror: assert property (i_re && i_addr == lnb_pkg::REG_STATUS
    |=> o_rdata[4:0] == {$past(o_out_code), $past(o_out_en)})
    else $error("status differs from output");
  a_code_follow: assert property (i_we && i_addr == lnb_pkg::REG_CTRL1
    && i_wdata[lnb_pkg::C1_BUS_SEL] |-> ##2 o_out_code == $past(i_wdata[4:1], 2))
    else $error("code not from register");
  a_en_follow: assert property (i_we && i_addr == lnb_pkg::REG_CTRL2 && !pin_mode_r
    |-> ##2 o_out_en == $past(i_wdata[lnb_pkg::C2_OUT_EN], 2))
    else $error("enable not from register");
  a_pin_off: assert property (pin_mode_r && low_cnt_r >= 4'ha |-> !o_out_en)
    else $error("output on with enable pin low");

  c_ack: cover property ($fell(o_sda_oe_n));
  c_reg_mode: cover property (i_we && i_addr == lnb_pkg::REG_CTRL1 && i_wdata[7]);
  c_pin_off: cover property (pin_mode_r && low_cnt_r == 4'ha);
endmodule // lnb_ctrl_chk

bind lnb_ctrl_top lnb_ctrl_chk i_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_scl(i_scl), .o_scl(o_scl),
  .o_scl_oe_n(o_scl_oe_n), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
  .i_en_pin(i_en_pin), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
  .i_re(i_re), .o_rdata(o_rdata), .o_out_en(o_out_en), .o_out_code(o_out_code)
);

// ### lnb_ctrl_top_tb.sv
`timescale 1ns/10ps
module lnb_ctrl_top_tb;
  logic       i_mclk, i_rst, i_en_pin, i_voltage_select_pin, i_we, i_re;
  logic [1:0] i_addr_strap;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic [3:0] o_out_code;
  logic       o_scl, o_scl_oe_n, o_sda, o_sda_oe_n, o_out_en;
  logic       scl_oe_n, sda_oe_n, scl_w, sda_w;
  int         fails, checks_done;

  // Pull-ups: a line is low only while someone pulls it
  assign scl_w = scl_oe_n & (o_scl_oe_n | o_scl);
  assign sda_w = sda_oe_n & (o_sda_oe_n | o_sda);

  lnb_ctrl_top i_dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_scl(scl_w), .o_scl(o_scl),
    .o_scl_oe_n(o_scl_oe_n), .i_sda(sda_w), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
    .i_en_pin(i_en_pin), .i_voltage_select_pin(i_voltage_select_pin),
    .i_addr_strap(i_addr_strap),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re),
    .o_rdata(o_rdata), .o_out_en(o_out_en), .o_out_code(o_out_code)
  );

  lnb_bus_ctl #(.HALF(10)) i_ctl (
    .i_mclk(i_mclk), .i_sda(sda_w), .o_scl_oe_n(scl_oe_n), .o_sda_oe_n(sda_oe_n)
  );

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic results();
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_we <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_re <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_re <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask

  task automatic chk_out(input logic e, input logic [3:0] c);
    repeat (12) @(posedge i_mclk);
    #1 chk({3'h0, o_out_en, o_out_code}, {3'h0, e, c});
  endtask

  task automatic rst_dut();
    i_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (10) @(posedge i_mclk);
  endtask

  task automatic t_reset_regs();
    rd(lnb_pkg::REG_CTRL1, 8'h08);
    rd(lnb_pkg::REG_CTRL2, 8'h09);
    rd(8'h02, 8'h00);
  endtask

  task automatic t_pin_mode();
    logic [3:0] codes [4];
    codes = '{4'h4, 4'hc, 4'h6, 4'he};
    for (int i = 0; i < 4; i++) begin
      i_ctl.set_scl(i[1]);
      i_voltage_select_pin <= i[0];
      chk_out(1'b1, codes[i]);
    end
    @(posedge i_mclk);
    i_en_pin <= 1'b0;
    repeat (14) @(posedge i_mclk);
    #1 chk({7'h0, o_out_en}, 8'h00);
  endtask

  task automatic t_reg_mode();
    wr(lnb_pkg::REG_CTRL1, 8'h9e);
    chk_out(1'b1, 4'hf);
    i_ctl.set_scl(1'b0);
    i_voltage_select_pin <= 1'b0;
    chk_out(1'b1, 4'hf);
    i_ctl.set_scl(1'b1);
    wr(lnb_pkg::REG_CTRL2, 8'h01);
    chk_out(1'b0, 4'hf);
    rd(lnb_pkg::REG_STATUS, 8'h1e);
    rd(lnb_pkg::REG_CTRL1, 8'h9e);
    wr(8'h02, 8'hff);
    rd(8'h02, 8'h00);
    wr(lnb_pkg::REG_CTRL1, 8'h08);
  endtask

  task automatic xfer(input logic [6:0] a, input logic nack, input logic [7:0] d);
    logic ack_n;
    i_ctl.start();
    i_ctl.send({a, 1'b0}, ack_n);
    chk({7'h0, ack_n}, {7'h0, nack});
    if (!nack) begin
      i_ctl.send(lnb_pkg::REG_CTRL1, ack_n);
      chk({7'h0, ack_n}, 8'h00);
      i_ctl.send(d, ack_n);
      chk({7'h0, ack_n}, 8'h00);
    end
    i_ctl.stop();
  endtask

  // Reads from the index left by the previous write
  task automatic xfer_rd(input logic [6:0] a, input logic [7:0] exp);
    logic       ack_n;
    logic [7:0] d;
    i_ctl.start();
    i_ctl.send({a, 1'b1}, ack_n);
    chk({7'h0, ack_n}, 8'h00);
    i_ctl.recv(1'b1, d);
    chk(d, exp);
    i_ctl.stop();
  endtask

  task automatic t_bus_strap();
    logic [6:0] adr [4];
    logic [7:0] d;
    adr = '{7'h08, 7'h09, 7'h10, 7'h11};
    for (int s = 0; s < 4; s++) begin
      d = {3'h0, 2'h2, 2'(s), 1'b0};
      @(posedge i_mclk);
      i_addr_strap <= 2'(s);
      rst_dut();
      xfer(adr[s], 1'b0, d);
      xfer_rd(adr[s], 8'h09);
      rd(lnb_pkg::REG_CTRL1, d);
      xfer(7'h00, 1'b1, 8'hff);
      xfer(adr[s ^ 1], 1'b1, 8'hff);
      rd(lnb_pkg::REG_CTRL1, d);
    end
  endtask

  // Whole run needs about 8.6k cycles
  initial begin
    repeat (40000) @(posedge i_mclk);
    fails++;
    results();
  end

  initial begin
    i_rst = 1'b1;
    i_en_pin = 1'b1;
    i_voltage_select_pin = 1'b0;
    i_we = 1'b0;
    i_re = 1'b0;
    i_addr_strap = 2'h0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    fails = 0;
    checks_done = 0;
    rst_dut();
    t_reset_regs();
    t_pin_mode();
    t_reg_mode();
    t_bus_strap();
    results();
  end
endmodule // lnb_ctrl_top_tb

// ### lnb_level_sel.sv
`timescale 1ns/10ps
module lnb_level_sel (
  input  wire logic       i_bus_sel,
  input  wire logic [3:0] i_reg_code,
  input  wire logic       i_reg_en,
  input  wire logic       i_pin_en,
  input  wire logic       i_scl,
  input  wire logic       i_voltage_select_pin,
  output lnb_pkg::lnb_level_t o_level
);

  always_comb begin
    o_level = '0;
    if (i_bus_sel) begin
      o_level.en   = i_reg_en;
      o_level.code = i_reg_code;
    end else begin
      o_level.en = i_pin_en;
      unique case ({i_scl, i_voltage_select_pin})
        2'b11:   o_level.code = lnb_pkg::CODE_19V4;
        2'b10:   o_level.code = lnb_pkg::CODE_14V6;
        2'b01:   o_level.code = lnb_pkg::CODE_18V2;
        2'b00:   o_level.code = lnb_pkg::CODE_13V4;
      endcase
    end
  end

endmodule // lnb_level_sel

// ### lnb_pin_sync.sv
`timescale 1ns/10ps
module lnb_pin_sync #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '1
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } lnb_sync_st_t;

  lnb_sync_st_t sync_r;
  lnb_sync_st_t sync_nxt;

  if (W < 1) begin : g_chk
    $error("lnb_pin_sync: W must be at least 1");
  end

  // Stage one feeds only stage two; glitch filter looks at stages two and three
  always_comb begin
    sync_nxt    = sync_r;
    sync_nxt.s1 = i_pin;
    sync_nxt.s2 = sync_r.s1;
    sync_nxt.s3 = sync_r.s2;
    for (int b = 0; b < W; b++) begin
      if (sync_r.s2[b] == sync_r.s3[b]) begin
        sync_nxt.q[b] = sync_r.s3[b];
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sync_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign o_level = sync_r.q;

endmodule // lnb_pin_sync

// ### lnb_pkg.sv
package lnb_pkg;

  // Register indices on both the plain port and the two-wire bus
  localparam logic [7:0] REG_CTRL1  = 8'h00;
  localparam logic [7:0] REG_CTRL2  = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h03;

  localparam logic [7:0] CTRL1_RST = 8'h08;
  localparam logic [7:0] CTRL2_RST = 8'h09;

  // Field positions
  localparam int C1_BUS_SEL  = 7;
  localparam int C1_CODE_LSB = 1;
  localparam int C1_CODE_MSB = 4;
  localparam int C2_OUT_EN   = 3;
  localparam int ST_OUT_EN   = 0;
  localparam int ST_CODE_LSB = 1;
  localparam int ST_CODE_MSB = 4;
  localparam int ST_BUSY     = 5;

  // Target addresses per strap level
  localparam logic [6:0] ADDR_VCC   = 7'h08;
  localparam logic [6:0] ADDR_FLOAT = 7'h09;
  localparam logic [6:0] ADDR_GND   = 7'h10;
  localparam logic [6:0] ADDR_DIV   = 7'h11;

  typedef enum logic [1:0] {
    STRAP_VCC   = 2'h0,
    STRAP_FLOAT = 2'h1,
    STRAP_GND   = 2'h2,
    STRAP_DIV   = 2'h3
  } lnb_strap_t;

  // Output voltage codes used by pin control
  localparam logic [3:0] CODE_13V4 = 4'h4;
  localparam logic [3:0] CODE_14V6 = 4'h6;
  localparam logic [3:0] CODE_18V2 = 4'hc;
  localparam logic [3:0] CODE_19V4 = 4'he;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef struct packed {
    logic       en;
    logic [3:0] code;
  } lnb_level_t;

  // Pins after synchronisation
  typedef struct packed {
    logic [1:0] strap;
    logic       en_pin;
    logic       voltage_select_pin;
    logic       scl;
    logic       sda;
  } lnb_pins_t;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_REG       = 4'h2,
    ST_REG_ACK   = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_RDATA_ACK = 4'hc,
    ST_SKIP      = 4'hd
  } lnb_state_t;

endpackage
